// file: logic/branch_core.sv
// executes boolean-carry, branch, call and return instructions and holds
// the pointer and accumulator registers; data memory lies outside and
// answers a read combinationally in the cycle the address is presented
//
// Operation
// - carry AND bit: two bytes, two cycles
// - carry OR bit or its complement: two bytes, two cycles
// - move bit to carry and carry to bit: two bytes, two cycles
// - branch on carry set or clear: two bytes, two or three cycles
// - bit branches three bytes, three or four cycles; test-clear clears the bit
// - page call/jump two bytes three cycles; long ones three bytes four
// - both returns one byte, five cycles
// - short relative branch two bytes, always three cycles
// - indirect jump to accumulator plus data pointer, one byte, three cycles
// - branch on accumulator zero or nonzero: two bytes, two or three cycles
// - compare-branch three bytes, 3/4 cycles; indirect form 4/5 cycles
// - decrement-branch: register 2 bytes 2/3, direct byte 3 bytes 3/4
// - idle instruction and spare opcode a5: one byte, one cycle
// - displacement is signed 8-bit, added to the next instruction address
// - page targets replace low eleven bits within the 2 kB page
// - long targets carry a full 16-bit address into 8 kB memory
// - direct addresses below 80 are data memory, above are sfr space
// - bank registers use selected bank; indirect pointer is r0 or r1
// - data pointer pair from low 82 and high 83, reset zero
// - stack pointer at 81 resets to 07, pre-incremented on each push
// - accumulator e0 and secondary f0 bit-addressable, reset zero
`timescale 1ns/1ps
module branch_core #(
  parameter int unsigned PROG_BYTES = 8192
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // instruction fetch
  output logic [15:0]      pc,
  input  wire logic [7:0]  code_byte0,
  input  wire logic [7:0]  code_byte1,
  input  wire logic [7:0]  code_byte2,
  output logic             instr_done,
  // carry and bank select from the status word
  input  wire logic        carry_in,
  input  wire logic [1:0]  bank_sel,
  output logic             carry_we,
  output logic             carry_out,
  // data memory and outside sfr space
  output logic [7:0]       mem_addr,
  output logic             mem_sfr,
  output logic             mem_we,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // core registers seen by the rest of the chip
  output logic [7:0]       acc_value,
  output logic [15:0]      data_pointer_pair_value,
  output logic [7:0]       sp_value,
  output logic [7:0]       b_value,
  output logic             interrupt_exit_pulse
);
  initial begin
    if (PROG_BYTES > 65536 || PROG_BYTES < 2048) begin
      $error("program size not servable");
    end
  end

  typedef enum logic [2:0] {S_EXEC, S_WAIT, S_PUSH_HI, S_POP_LO} phase_t;
  typedef struct packed {
    phase_t      phase;
    logic [15:0] pc;
    logic [15:0] tgt;
    logic [2:0]  left;
    logic [7:0]  sp;
    logic [7:0]  data_pointer_low;
    logic [7:0]  data_pointer_high;
    logic [7:0]  acc;
    logic [7:0]  b;
    logic        done;
    logic        interrupt_exit;
  } state_t;
  state_t q, d;

  //////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] rel_target(input logic [15:0] nxt,
                                             input logic [7:0] disp);
    rel_target = nxt + {{8{disp[7]}}, disp};
  endfunction : rel_target

  function automatic logic [7:0] bank_reg(input logic [1:0] bank,
                                          input logic [2:0] idx);
    bank_reg = {3'h0, bank, idx};
  endfunction : bank_reg

  // sfr reads of the block's own registers
  function automatic logic own_sfr(input logic [7:0] a);
    own_sfr = a == branch_core_pkg::STACK_POINTER_ADDR || a == branch_core_pkg::DATA_POINTER_PAIR_LOW_ADDR
           || a == branch_core_pkg::DATA_POINTER_PAIR_HIGH_ADDR || a == branch_core_pkg::PRIMARY_ADDR
           || a == branch_core_pkg::SECONDARY_ADDR;
  endfunction : own_sfr

  //////////////////////////////////////////////////////////////////////////
  // bit address decode
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  bit_locator u_bit (
    .bit_addr  (code_byte1),
    .byte_addr (bit_byte),
    .bit_pos   (bit_pos)
  );

  logic [7:0] op;
  logic [7:0] rd_byte;
  logic       bitv;
  logic [7:0] own_rd;
  logic [15:0] n2;
  logic [15:0] n3;
  assign op = code_byte0;
  assign n2 = q.pc + 16'h0002;
  assign n3 = q.pc + 16'h0003;

  // the block answers reads of its own sfrs, the rest come from outside
  always_comb begin
    unique case (mem_addr)
      branch_core_pkg::STACK_POINTER_ADDR: own_rd = q.sp;
      branch_core_pkg::DATA_POINTER_PAIR_LOW_ADDR:      own_rd = q.data_pointer_low;
      branch_core_pkg::DATA_POINTER_PAIR_HIGH_ADDR:     own_rd = q.data_pointer_high;
      branch_core_pkg::PRIMARY_ADDR:       own_rd = q.acc;
      branch_core_pkg::SECONDARY_ADDR:     own_rd = q.b;
      default:                             own_rd = 8'h00;
    endcase
  end
  assign rd_byte = (mem_sfr && own_sfr(mem_addr)) ? own_rd : mem_rdata;
  assign bitv = rd_byte[bit_pos];

  //////////////////////////////////////////////////////////////////////////
  // execute: one pass decides the result, the wait phase pads the cycles
  always_comb begin
    logic       taken;
    logic [7:0] cmp;
    logic [7:0] dec;
    logic [1:0] extra;
    taken = 1'b0;
    cmp = 8'h00;
    dec = 8'h00;
    extra = 2'd0;
    d = q;
    d.done = 1'b0;
    carry_we = 1'b0;
    carry_out = carry_in;
    mem_addr = 8'h00;
    mem_sfr = 1'b0;
    mem_we = 1'b0;
    mem_wdata = 8'h00;
    unique case (q.phase)
      S_EXEC: begin
        d.tgt = q.pc + 16'h0001; // idle and spare opcode
        d.left = 3'd0;
        // return kind is kept until the completing cycle, cleared at each new instruction
        d.interrupt_exit = 1'b0;
        // bit operand fetched for every bit instruction
        mem_addr = bit_byte;
        mem_sfr = code_byte1[branch_core_pkg::SFR_SPACE_BIT];
        if (op == branch_core_pkg::OP_ANL_C || op == branch_core_pkg::OP_ANL_NC) begin
          carry_we = 1'b1;
          carry_out = carry_in & (bitv ^ op[5]);
          d.tgt = n2;
          d.left = 3'd1;
        end else if (op == branch_core_pkg::OP_ORL_C || op == branch_core_pkg::OP_ORL_NC) begin
          carry_we = 1'b1;
          carry_out = carry_in | (bitv ^ op[7]);
          d.tgt = n2;
          d.left = 3'd1;
        end else if (op == branch_core_pkg::OP_MOV_CB) begin
          carry_we = 1'b1;
          carry_out = bitv;
          d.tgt = n2;
          d.left = 3'd1;
        end else if (op == branch_core_pkg::OP_MOV_BC) begin
          mem_we = 1'b1;
          mem_wdata = rd_byte;
          mem_wdata[bit_pos] = carry_in;
          d.tgt = n2;
          d.left = 3'd1;
        end else if (op == branch_core_pkg::OP_JC || op == branch_core_pkg::OP_JNC) begin
          taken = carry_in ^ op[4];
          d.tgt = taken ? rel_target(n2, code_byte1) : n2;
          d.left = taken ? 3'd2 : 3'd1;
        end else if (op == branch_core_pkg::OP_JB || op == branch_core_pkg::OP_JNB
                     || op == branch_core_pkg::OP_JBC) begin
          taken = (op == branch_core_pkg::OP_JNB) ? ~bitv : bitv;
          if (op == branch_core_pkg::OP_JBC && bitv) begin
            mem_we = 1'b1;
            mem_wdata = rd_byte;
            mem_wdata[bit_pos] = 1'b0;
          end
          d.tgt = taken ? rel_target(n3, code_byte2) : n3;
          d.left = taken ? 3'd3 : 3'd2;
        end else if (op[4:0] == branch_core_pkg::OP_PAGE_JMP
                     || op[4:0] == branch_core_pkg::OP_PAGE_CALL) begin
          d.tgt = {n2[15:branch_core_pkg::PAGE_BITS], op[7:5], code_byte1};
          d.left = 3'd2;
          if (op[4]) begin
            d.sp = q.sp + 8'h01;
            mem_addr = q.sp + 8'h01;
            mem_sfr = 1'b0;
            mem_we = 1'b1;
            mem_wdata = n2[7:0];
            d.pc = n2; // high return byte pushed next
            d.phase = S_PUSH_HI;
          end
        end else if (op == branch_core_pkg::OP_LONG_ABSOLUTE_BRANCH || op == branch_core_pkg::OP_LONG_CALL) begin
          d.tgt = {code_byte1, code_byte2};
          d.left = 3'd3;
          if (op == branch_core_pkg::OP_LONG_CALL) begin
            d.sp = q.sp + 8'h01;
            mem_addr = q.sp + 8'h01;
            mem_sfr = 1'b0;
            mem_we = 1'b1;
            mem_wdata = n3[7:0];
            d.pc = n3;
            d.phase = S_PUSH_HI;
          end
        end else if (op == branch_core_pkg::OP_RET || op == branch_core_pkg::OP_INTERRUPT_EXIT) begin
          mem_addr = q.sp; // high byte first
          mem_sfr = 1'b0;
          d.tgt = {rd_byte, 8'h00};
          d.sp = q.sp - 8'h01;
          d.left = 3'd4;
          d.interrupt_exit = op[4];
          d.phase = S_POP_LO;
        end else if (op == branch_core_pkg::OP_SHORT_RELATIVE_BRANCH) begin
          d.tgt = rel_target(n2, code_byte1);
          d.left = 3'd2;
        end else if (op == branch_core_pkg::OP_JMP_IND) begin
          d.tgt = {q.data_pointer_high, q.data_pointer_low} + {8'h00, q.acc};
          d.left = 3'd2;
        end else if (op == branch_core_pkg::OP_JZ || op == branch_core_pkg::OP_JNZ) begin
          taken = (q.acc == 8'h00) ^ op[4];
          d.tgt = taken ? rel_target(n2, code_byte1) : n2;
          d.left = taken ? 3'd2 : 3'd1;
        end else if (op[7:4] == 4'hb && op[3:0] >= 4'h4) begin
          // compare-branch forms only the direct form may reach sfr space
          extra = 2'd0;
          mem_sfr = 1'b0;
          if (op == branch_core_pkg::OP_COMPARE_BRANCH_UNEQUAL_AD) begin
            mem_addr = code_byte1;
            mem_sfr = code_byte1[branch_core_pkg::SFR_SPACE_BIT];
            cmp = rd_byte;
          end else if (op == branch_core_pkg::OP_COMPARE_BRANCH_UNEQUAL_AI) begin
            cmp = code_byte1;
          end else if (op[3:1] == branch_core_pkg::OP_COMPARE_BRANCH_UNEQUAL_IND[3:1]) begin
            cmp = code_byte1;
            extra = 2'd1;
          end else begin
            mem_addr = bank_reg(bank_sel, op[2:0]);
            cmp = code_byte1;
          end
          if (op[3:1] == branch_core_pkg::OP_COMPARE_BRANCH_UNEQUAL_IND[3:1]) begin
            // indirect operand: the pointer register r0/r1 itself is read and compared, no target byte fetch
            mem_addr = bank_reg(bank_sel, {2'b00, op[0]});
          end
          if (op[3:0] == 4'h4 || op[3:0] == 4'h5) taken = q.acc != cmp;
          else if (op[3]) taken = rd_byte != cmp;
          else taken = mem_rdata != code_byte1; // indirect compare on fetched byte
          carry_we = 1'b1;
          carry_out = (op[3:0] <= 4'h5) ? (q.acc < cmp) : (rd_byte < code_byte1);
          d.tgt = taken ? rel_target(n3, code_byte2) : n3;
          d.left = (taken ? 3'd3 : 3'd2) + {1'b0, extra};
        end else if (op == branch_core_pkg::OP_DECREMENT_BRANCH_NONZERO_DIR || op[7:3] == 5'b11011) begin
          if (op[3]) mem_addr = bank_reg(bank_sel, op[2:0]);
          else mem_addr = code_byte1;
          mem_sfr = ~op[3] & code_byte1[branch_core_pkg::SFR_SPACE_BIT];
          dec = rd_byte - 8'h01;
          mem_we = 1'b1;
          mem_wdata = dec;
          taken = dec != 8'h00;
          if (op[3]) begin
            d.tgt = taken ? rel_target(n2, code_byte1) : n2;
            d.left = taken ? 3'd2 : 3'd1;
          end else begin
            d.tgt = taken ? rel_target(n3, code_byte2) : n3;
            d.left = taken ? 3'd3 : 3'd2;
          end
        end
        // own sfr writes land here too; mem_we still drives them out to outside memory
        if (mem_we && mem_sfr && own_sfr(mem_addr)) begin
          unique case (mem_addr)
            branch_core_pkg::STACK_POINTER_ADDR: d.sp = mem_wdata;
            branch_core_pkg::DATA_POINTER_PAIR_LOW_ADDR:      d.data_pointer_low = mem_wdata;
            branch_core_pkg::DATA_POINTER_PAIR_HIGH_ADDR:     d.data_pointer_high = mem_wdata;
            branch_core_pkg::PRIMARY_ADDR:       d.acc = mem_wdata;
            default:                             d.b = mem_wdata;
          endcase
        end
        if (d.phase == S_EXEC) begin
          if (d.left == 3'd0) begin
            d.pc = d.tgt;
            d.done = 1'b1;
          end else begin
            d.phase = S_WAIT;
          end
        end
      end
      S_PUSH_HI: begin
        d.sp = q.sp + 8'h01;
        mem_addr = q.sp + 8'h01;
        mem_we = 1'b1;
        mem_wdata = q.pc[15:8];
        d.left = q.left - 3'd1;
        d.phase = S_WAIT;
      end
      S_POP_LO: begin
        mem_addr = q.sp;
        d.tgt = {q.tgt[15:8], mem_rdata};
        d.sp = q.sp - 8'h01;
        d.left = q.left - 3'd1;
        d.phase = S_WAIT;
      end
      S_WAIT: begin
        d.left = q.left - 3'd1;
        if (q.left == 3'd1) begin
          d.pc = q.tgt;
          d.done = 1'b1;
          d.phase = S_EXEC;
        end
      end
      default: d.phase = S_EXEC;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{phase: S_EXEC, pc: branch_core_pkg::PC_RST, tgt: branch_core_pkg::PC_RST,
             left: 3'd0, sp: branch_core_pkg::STACK_POINTER_RST,
             data_pointer_low: branch_core_pkg::DATA_POINTER_PAIR_LOW_RST, data_pointer_high: branch_core_pkg::DATA_POINTER_PAIR_HIGH_RST,
             acc: branch_core_pkg::PRIMARY_RST, b: branch_core_pkg::SECONDARY_RST,
             done: 1'b0, interrupt_exit: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pc = q.pc;
  assign instr_done = q.done;
  assign acc_value = q.acc;
  assign data_pointer_pair_value = {q.data_pointer_high, q.data_pointer_low};
  assign sp_value = q.sp;
  assign b_value = q.b;
  // pulse only in the cycle the interrupt return completes
  assign interrupt_exit_pulse = q.interrupt_exit & q.done;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_idle_one;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && (op == branch_core_pkg::OP_IDLE || op == branch_core_pkg::OP_SPARE))
      |=> (q.done && q.pc == $past(q.pc) + 16'h0001);
  endproperty
  a_idle_one: assert property (p_idle_one) else $error("idle not one cycle");
  property p_ret_five;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && op == branch_core_pkg::OP_RET) |=> !q.done [*4] ##1 q.done;
  endproperty
  a_ret_five: assert property (p_ret_five) else $error("return not five cycles");
  property p_short_relative_branch_three;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && op == branch_core_pkg::OP_SHORT_RELATIVE_BRANCH) |=> !q.done ##1 !q.done ##1 q.done;
  endproperty
  a_short_relative_branch_three: assert property (p_short_relative_branch_three) else $error("short branch timing");
  property p_long_absolute_branch_four;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && op == branch_core_pkg::OP_LONG_ABSOLUTE_BRANCH) |=> !q.done [*3] ##1
      (q.done && q.pc == {$past(code_byte1, 4), $past(code_byte2, 4)});
  endproperty
  a_long_absolute_branch_four: assert property (p_long_absolute_branch_four) else $error("long jump wrong");
  property p_jc_time;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && op == branch_core_pkg::OP_JC && !carry_in) |=> !q.done ##1 q.done;
  endproperty
  a_jc_time: assert property (p_jc_time) else $error("untaken carry branch");
  property p_anl_two;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && op == branch_core_pkg::OP_ANL_C) |-> carry_we ##1 !q.done ##1 q.done;
  endproperty
  a_anl_two: assert property (p_anl_two) else $error("carry and timing");
  property p_jz_taken;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && op == branch_core_pkg::OP_JZ && q.acc == 8'h00)
      |=> !q.done [*2] ##1 q.done;
  endproperty
  a_jz_taken: assert property (p_jz_taken) else $error("taken zero branch");
  property p_call_push;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.phase == S_EXEC && op == branch_core_pkg::OP_LONG_CALL) |=> q.sp == $past(q.sp) + 8'h01
      ##1 q.sp == $past(q.sp, 2) + 8'h02;
  endproperty
  a_call_push: assert property (p_call_push) else $error("push order");
  c_ret: cover property (@(posedge ref_clk) q.phase == S_EXEC && op == branch_core_pkg::OP_INTERRUPT_EXIT);
  c_jbc: cover property (@(posedge ref_clk) q.phase == S_EXEC && op == branch_core_pkg::OP_JBC
                         && bitv);
  c_call: cover property (@(posedge ref_clk) q.phase == S_PUSH_HI);
endmodule : branch_core

// file: common/branch_core_pkg.sv
// package for the boolean, branch and core-register execution block
// assumes one 40 MHz clock and an 8051-style opcode map
package branch_core_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // special function register offsets
  localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
  localparam logic [7:0] DATA_POINTER_PAIR_LOW_ADDR      = 8'h82;
  localparam logic [7:0] DATA_POINTER_PAIR_HIGH_ADDR     = 8'h83;
  localparam logic [7:0] PSW_ADDR           = 8'hd0;
  localparam logic [7:0] PRIMARY_ADDR       = 8'he0;
  localparam logic [7:0] SECONDARY_ADDR     = 8'hf0;
  // reset values
  localparam logic [7:0] STACK_POINTER_RST  = 8'h07;
  localparam logic [7:0] DATA_POINTER_PAIR_LOW_RST       = 8'h00;
  localparam logic [7:0] DATA_POINTER_PAIR_HIGH_RST      = 8'h00;
  localparam logic [7:0] PRIMARY_RST        = 8'h00;
  localparam logic [7:0] SECONDARY_RST      = 8'h00;
  localparam logic [15:0] PC_RST            = 16'h0000;
  // direct space split and bit-address fields
  localparam int unsigned SFR_SPACE_BIT     = 7;
  localparam logic [7:0] BIT_AREA_BASE      = 8'h20;
  localparam int unsigned PAGE_BITS         = 11;
  localparam int unsigned PROG_SIZE_BYTES   = 8192;
  localparam int unsigned BANK_POS          = 3;
  // opcodes
  localparam logic [7:0] OP_IDLE      = 8'h00;
  localparam logic [7:0] OP_SPARE     = 8'ha5;
  localparam logic [7:0] OP_ANL_C     = 8'h82;
  localparam logic [7:0] OP_ANL_NC    = 8'hb0;
  localparam logic [7:0] OP_ORL_C     = 8'h72;
  localparam logic [7:0] OP_ORL_NC    = 8'ha0;
  localparam logic [7:0] OP_MOV_CB    = 8'ha2;
  localparam logic [7:0] OP_MOV_BC    = 8'h92;
  localparam logic [7:0] OP_JC        = 8'h40;
  localparam logic [7:0] OP_JNC       = 8'h50;
  localparam logic [7:0] OP_JB        = 8'h20;
  localparam logic [7:0] OP_JNB       = 8'h30;
  localparam logic [7:0] OP_JBC       = 8'h10;
  localparam logic [7:0] OP_LONG_CALL     = 8'h12;
  localparam logic [7:0] OP_LONG_ABSOLUTE_BRANCH      = 8'h02;
  localparam logic [7:0] OP_RET       = 8'h22;
  localparam logic [7:0] OP_INTERRUPT_EXIT      = 8'h32;
  localparam logic [7:0] OP_SHORT_RELATIVE_BRANCH      = 8'h80;
  localparam logic [7:0] OP_JMP_IND   = 8'h73;
  localparam logic [7:0] OP_JZ        = 8'h60;
  localparam logic [7:0] OP_JNZ       = 8'h70;
  localparam logic [7:0] OP_COMPARE_BRANCH_UNEQUAL_AD   = 8'hb5;
  localparam logic [7:0] OP_COMPARE_BRANCH_UNEQUAL_AI   = 8'hb4;
  localparam logic [7:0] OP_COMPARE_BRANCH_UNEQUAL_IND  = 8'hb6; // b6/b7
  localparam logic [7:0] OP_COMPARE_BRANCH_UNEQUAL_REG  = 8'hb8; // b8..bf
  localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_DIR  = 8'hd5;
  localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_REG  = 8'hd8; // d8..df
  localparam logic [4:0] OP_PAGE_JMP  = 5'b00001; // low five bits of page jump
  localparam logic [4:0] OP_PAGE_CALL = 5'b10001; // low five bits of page call
endpackage : branch_core_pkg

// file: logic/bit_locator.sv
// turns a bit address into the byte that holds it and the bit position
// assumes bit addresses 00..7f map into 20..2f and 80..ff into sfr bytes
`timescale 1ns/1ps
module bit_locator (
  // bit address in
  input  wire logic [7:0] bit_addr,
  // byte address and lane out
  output logic [7:0]      byte_addr,
  output logic [2:0]      bit_pos
);
  // sfr bits live in bytes whose low three address bits are zero
  always_comb begin
    bit_pos = bit_addr[2:0];
    if (bit_addr[branch_core_pkg::SFR_SPACE_BIT]) begin
      byte_addr = {bit_addr[7:3], 3'h0};
    end else begin
      byte_addr = branch_core_pkg::BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
    end
  end
endmodule : bit_locator

// file: bench/tb_branch_core.sv
// self-checking bench for the branch and core-register block: runs a short program
// assumes code and data memory are modelled here and read combinationally
`timescale 1ns/1ps
module tb_branch_core;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] pc;
  logic [7:0]  code_byte0, code_byte1, code_byte2;
  logic        instr_done, carry_we, carry_out, mem_sfr, mem_we, interrupt_exit_pulse;
  logic        cy = 1'b0;
  logic [1:0]  bank_sel = 2'b01;
  logic [7:0]  mem_addr, mem_wdata, mem_rdata, acc_value, sp_value, b_value;
  logic [15:0] data_pointer_pair_value;
  logic [7:0]  prog [0:8191];
  logic [7:0]  dmem [0:255];
  logic [7:0]  sfr_ext [0:255];
  logic [15:0] exp_pc_q [$];
  int          exp_n_q [$];
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling so a stuck fetch cannot hang the run
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // memories answer in the same cycle; direct writes land in ram or sfr by the space flag
  assign code_byte0 = prog[pc[12:0]];
  assign code_byte1 = prog[13'(pc + 16'h0001)];
  assign code_byte2 = prog[13'(pc + 16'h0002)];
  assign mem_rdata  = mem_sfr ? sfr_ext[mem_addr] : dmem[mem_addr];
  always @(posedge ref_clk) begin
    if (carry_we === 1'b1) cy <= carry_out;
    if (mem_we === 1'b1 && mem_sfr === 1'b1) sfr_ext[mem_addr] <= mem_wdata;
    if (mem_we === 1'b1 && mem_sfr === 1'b0) dmem[mem_addr] <= mem_wdata;
  end

  branch_core #(.PROG_BYTES(8192)) branch_core_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .pc(pc), .code_byte0(code_byte0),
    .code_byte1(code_byte1), .code_byte2(code_byte2), .instr_done(instr_done),
    .carry_in(cy), .bank_sel(bank_sel), .carry_we(carry_we), .carry_out(carry_out),
    .mem_addr(mem_addr), .mem_sfr(mem_sfr), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .acc_value(acc_value), .data_pointer_pair_value(data_pointer_pair_value),
    .sp_value(sp_value), .b_value(b_value), .interrupt_exit_pulse(interrupt_exit_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // place one instruction and the pc and cycle count it must end with
  task automatic put(input logic [15:0] a, input logic [7:0] o, b1, b2,
                     input logic [15:0] npc, input int n);
    prog[a[12:0]] = o;
    prog[13'(a + 16'h0001)] = b1;
    prog[13'(a + 16'h0002)] = b2;
    exp_pc_q.push_back(npc);
    exp_n_q.push_back(n);
  endtask : put

  // count edges from the last completion to the next one
  task automatic run(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (instr_done !== 1'b1 && n < 10);
      chk(pc, exp_pc_q.pop_front());
      chk(16'(n), 16'(exp_n_q.pop_front()));
    end
  endtask : run

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: program laid out in execution order, later bytes win
  initial begin
    for (int i = 0; i < 8192; i++) prog[i] = 8'h00;
    for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
    for (int i = 0; i < 256; i++) sfr_ext[i] = 8'h00; // reserved bits kept at zero
    dmem[8'h20] = 8'h03;
    dmem[8'h40] = 8'h01;
    put(16'h0000, 8'h00, 8'h00, 8'h00, 16'h0001, 1);
    put(16'h0001, 8'ha5, 8'h00, 8'h00, 16'h0002, 1);
    put(16'h0002, 8'h80, 8'h02, 8'h00, 16'h0006, 3);
    put(16'h0006, 8'h40, 8'h10, 8'h00, 16'h0008, 2);
    put(16'h0008, 8'ha2, 8'h00, 8'h00, 16'h000a, 2);
    put(16'h000a, 8'h50, 8'h10, 8'h00, 16'h000c, 2);
    put(16'h000c, 8'h40, 8'h10, 8'h00, 16'h001e, 3);
    put(16'h001e, 8'h10, 8'h01, 8'h0f, 16'h0030, 4);
    put(16'h0030, 8'h20, 8'h01, 8'h10, 16'h0033, 3);
    put(16'h0033, 8'h12, 8'h01, 8'h00, 16'h0100, 4);
    put(16'h0100, 8'h22, 8'h00, 8'h00, 16'h0036, 5);
    put(16'h0036, 8'h02, 8'h18, 8'h00, 16'h1800, 4);
    put(16'h1800, 8'h31, 8'h55, 8'h00, 16'h1955, 3);
    put(16'h1955, 8'h32, 8'h00, 8'h00, 16'h1802, 5);
    put(16'h1802, 8'h01, 8'h10, 8'h00, 16'h1810, 3);
    put(16'h1810, 8'h60, 8'h0e, 8'h00, 16'h1820, 3);
    put(16'h1820, 8'h92, 8'he1, 8'h00, 16'h1822, 2);
    put(16'h1822, 8'h70, 8'h0c, 8'h00, 16'h1830, 3);
    put(16'h1830, 8'h60, 8'h10, 8'h00, 16'h1832, 2);
    put(16'h1832, 8'hd5, 8'h82, 8'h0d, 16'h1842, 4);
    put(16'h1842, 8'h73, 8'h00, 8'h00, 16'h0101, 3);
    put(16'h0101, 8'hd8, 8'hfe, 8'h00, 16'h0101, 3);
    put(16'h0101, 8'hd8, 8'hfe, 8'h00, 16'h0103, 2);
    put(16'h0103, 8'hb4, 8'h02, 8'h10, 16'h0106, 3);
    put(16'h0106, 8'hb6, 8'h05, 8'h07, 16'h0110, 5);
    put(16'h0110, 8'h82, 8'h01, 8'h00, 16'h0112, 2);
    put(16'h0112, 8'ha0, 8'h01, 8'h00, 16'h0114, 2);
    put(16'h0114, 8'hb0, 8'h00, 8'h00, 16'h0116, 2);
    put(16'h0116, 8'h72, 8'h00, 8'h00, 16'h0118, 2);
    put(16'h0118, 8'h30, 8'h01, 8'h05, 16'h0120, 4);
    put(16'h0120, 8'hd5, 8'h40, 8'h10, 16'h0123, 3);
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk(sp_value, 16'h0007);
    chk(data_pointer_pair_value, 16'h0000);
    chk(acc_value, 16'h0000);
    chk(b_value, 16'h0000);
    run(7);
    chk(cy, 1'b1);
    run(1);
    chk(dmem[8'h20], 16'h0001);
    run(2);
    chk(sp_value, 16'h0009);
    chk({dmem[8'h09], dmem[8'h08]}, 16'h0036);
    run(1);
    chk(sp_value, 16'h0007);
    run(2);
    chk({dmem[8'h09], dmem[8'h08]}, 16'h1802);
    run(1);
    chk(interrupt_exit_pulse, 1'b1);
    run(3);
    chk(acc_value, 16'h0002);
    run(3);
    chk(data_pointer_pair_value, 16'h00ff);
    run(3);
    chk(dmem[8'h08], 16'h0000);
    run(2);
    for (int i = 0; i < 4; i++) begin
      run(1);
      chk(cy, i[0]);
    end
    run(2);
    chk(dmem[8'h40], 16'h0000);
    print_verdict();
  end
endmodule : tb_branch_core
